// >>> bsm_params.svh
// Constants for the press brake stop time monitor: timing, limits and register map.
`ifndef BSM_PARAMS_SVH
`define BSM_PARAMS_SVH

`define BSM_CLK_PERIOD_NS 4
`define BSM_MS_NS 1000000
`define BSM_MS_CYCLES (`BSM_MS_NS / `BSM_CLK_PERIOD_NS)
`define BSM_PRESCALE_W 18

`define BSM_MS_W 16
`define BSM_MS_MAX 16'hffff
`define BSM_STOP_GAP_MS 16'h0005
`define BSM_SPEED_WIN_MS 16'h003c
`define BSM_DRIVE_STEP_MS 12'h064

`define BSM_SP_W 10
`define BSM_SP_MIN 10'h001
`define BSM_SP_MAX 10'h3e7
`define BSM_WARN_RST 10'h064
`define BSM_LIMIT_RST 10'h0c8

`define BSM_TMO_W 5
`define BSM_TMO_MIN 5'h01
`define BSM_TMO_MAX 5'h19
`define BSM_TMO_RST 5'h0a

`define BSM_ADDR_W 6
`define BSM_REG_STATUS 6'h00
`define BSM_REG_WARN_SP 6'h04
`define BSM_REG_LIMIT_SP 6'h08
`define BSM_REG_STOP_TIME 6'h0c
`define BSM_REG_SPEED 6'h10
`define BSM_REG_IRQ_STAT 6'h14
`define BSM_REG_IRQ_MASK 6'h18
`define BSM_REG_DRIVE_TMO 6'h1c

`define BSM_ST_IND_LSB 0
`define BSM_ST_MODE_LSB 12
`define BSM_ST_FAULT_LSB 16
`define BSM_ST_MOTION_BIT 20

`define BSM_IRQ_W 4
`define BSM_IRQ_STOP 0
`define BSM_IRQ_WARN 1
`define BSM_IRQ_BRAKE 2
`define BSM_IRQ_DRIVE 3

`endif

// >>> bsm_pkg.sv
// Types shared by the press brake stop time monitor.
package bsm_pkg;

    typedef enum logic [1:0] {
        MODE_WARN_EDIT,
        MODE_LIMIT_EDIT,
        MODE_RESET,
        MODE_RUN
    } bsm_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ENGAGED,
        ST_BRAKING
    } bsm_meas_t;

    typedef struct packed {
        logic [1:0] key;
        logic minus_btn;
        logic plus_btn;
        logic valve_on;
        logic enc_pulse;
    } bsm_pins_t;

    typedef struct packed {
        logic limit_sp;
        logic warn_sp;
        logic speed;
        logic stop_time;
        logic brake_fail;
        logic not_ready;
        logic ready;
        logic brake_on;
        logic drive_fail;
        logic brake_warn;
    } bsm_ind_t;

    typedef struct packed {
        logic drive;
        logic brake;
    } bsm_fault_t;

    typedef struct packed {
        bsm_fault_t fault;
        logic [15:0] stop_ms;
        logic [9:0] warn_sp;
        logic [9:0] limit_sp;
    } bsm_nv_rec_t;

endpackage : bsm_pkg

// >>> bsm_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module bsm_sync #(
    parameter int WIDTH = 6
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                meta_r[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else if (clk_en_in) begin
                meta_r[i] <= async_in[i];
                sync_out[i] <= meta_r[i];
            end
        end
    end
endmodule : bsm_sync

// >>> bsm_monitor.sv
// Press brake stopping time monitor with Avalon-MM register slave.
`timescale 1ns/10ps
`include "bsm_params.svh"
module bsm_monitor #(
    parameter int MS_CYCLES = `BSM_MS_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire bsm_pkg::bsm_pins_t pins_in,
    input wire logic nv_load_in,
    input wire bsm_pkg::bsm_nv_rec_t nv_rec_in,
    output bsm_pkg::bsm_nv_rec_t nv_rec_out,
    output logic nv_save_out,
    output logic relay_on_out,
    output bsm_pkg::bsm_ind_t ind_out,
    output logic [15:0] display_out,
    output logic irq_out,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    import bsm_pkg::*;

    localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

    bsm_pins_t pins_s;
    logic enc_d_r;
    logic [17:0] presc_r;
    logic [15:0] gap_ms_r;
    logic [15:0] stop_cnt_r;
    logic [15:0] stop_last_r;
    logic [15:0] stop_time_r;
    logic [15:0] win_ms_r;
    logic [15:0] win_cnt_r;
    logic [15:0] speed_r;
    logic [9:0] warn_sp_r;
    logic [9:0] limit_sp_r;
    logic [4:0] drive_tmo_r;
    logic plus_d_r;
    logic minus_d_r;
    logic warn_lit_r;
    logic stop_shown_r;
    bsm_fault_t fault_r;
    bsm_meas_t meas_r;
    bsm_mode_t mode;
    bsm_mode_t mode_d_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic ack_r;

    bsm_sync #(
        .WIDTH($bits(bsm_pins_t))
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .async_in(pins_in),
        .sync_out(pins_s)
    );

    // Key decode: every code of the two-bit selector is a legal mode.
    always_comb begin
        unique case (pins_s.key)
            2'h0: mode = MODE_WARN_EDIT;
            2'h1: mode = MODE_LIMIT_EDIT;
            2'h2: mode = MODE_RESET;
            2'h3: mode = MODE_RUN;
        endcase
    end

    wire ms_tick = (presc_r == MS_LAST);
    wire enc_rise = pins_s.enc_pulse & ~enc_d_r;
    wire plus_rise = pins_s.plus_btn & ~plus_d_r;
    wire minus_rise = pins_s.minus_btn & ~minus_d_r;
    wire motion = (gap_ms_r < `BSM_STOP_GAP_MS);
    wire [11:0] drive_ms = 12'(drive_tmo_r * `BSM_DRIVE_STEP_MS);
    wire drive_stall = pins_s.valve_on && (gap_ms_r >= {4'h0, drive_ms});
    wire stop_done = (meas_r == ST_BRAKING) && !pins_s.valve_on && !motion;
    wire over_warn = stop_done && (stop_last_r > {6'h00, warn_sp_r});
    wire over_limit = stop_done && (stop_last_r > {6'h00, limit_sp_r});
    wire drive_evt = drive_stall && !fault_r.drive;
    wire brake_evt = over_limit && !fault_r.brake;
    wire fault_any = fault_r.drive | fault_r.brake;
    wire in_edit = (mode == MODE_WARN_EDIT) || (mode == MODE_LIMIT_EDIT);
    // Setpoints are frozen while the crank turns.
    wire sp_ok = in_edit && !motion;
    wire step_up = sp_ok && plus_rise && !minus_rise;
    wire step_dn = sp_ok && minus_rise && !plus_rise;
    wire edit_done = ((mode_d_r == MODE_WARN_EDIT) || (mode_d_r == MODE_LIMIT_EDIT)) && !in_edit;
    wire relay_nxt = (mode == MODE_RUN) && !fault_any && !drive_evt && !brake_evt;
    wire [3:0] irq_evt = {drive_evt, brake_evt, over_warn, stop_done};

    // Millisecond prescaler and encoder gap timer.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            presc_r <= 18'h00000;
            enc_d_r <= 1'b0;
            plus_d_r <= 1'b0;
            minus_d_r <= 1'b0;
            gap_ms_r <= `BSM_MS_MAX;
        end else if (clk_en_in) begin
            presc_r <= ms_tick ? 18'h00000 : presc_r + 18'h00001;
            enc_d_r <= pins_s.enc_pulse;
            plus_d_r <= pins_s.plus_btn;
            minus_d_r <= pins_s.minus_btn;
            if (enc_rise) begin
                gap_ms_r <= 16'h0000;
            end else if (ms_tick && gap_ms_r != `BSM_MS_MAX) begin
                gap_ms_r <= gap_ms_r + 16'h0001;
            end
        end
    end

    // Speed: with 1000 pulses per turn, pulses in a 60 ms window equal strokes per minute.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            win_ms_r <= 16'h0000;
            win_cnt_r <= 16'h0000;
            speed_r <= 16'h0000;
        end else if (clk_en_in) begin
            if (ms_tick && win_ms_r == `BSM_SPEED_WIN_MS - 16'h0001) begin
                win_ms_r <= 16'h0000;
                speed_r <= win_cnt_r;
                win_cnt_r <= {15'h0000, enc_rise};
            end else begin
                if (ms_tick) begin
                    win_ms_r <= win_ms_r + 16'h0001;
                end
                if (enc_rise && win_cnt_r != `BSM_MS_MAX) begin
                    win_cnt_r <= win_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Stop measurement sequence.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meas_r <= ST_IDLE;
            stop_cnt_r <= 16'h0000;
            stop_last_r <= 16'h0000;
        end else if (clk_en_in) begin
            unique case (meas_r)
                ST_IDLE: begin
                    if (pins_s.valve_on) begin
                        meas_r <= ST_ENGAGED;
                    end
                end
                ST_ENGAGED: begin
                    if (!pins_s.valve_on) begin
                        meas_r <= ST_BRAKING;
                        stop_cnt_r <= 16'h0000;
                        stop_last_r <= 16'h0000;
                    end
                end
                ST_BRAKING: begin
                    if (pins_s.valve_on) begin
                        meas_r <= ST_ENGAGED;
                    end else if (stop_done) begin
                        meas_r <= ST_IDLE;
                    end
                    if (ms_tick && stop_cnt_r != `BSM_MS_MAX) begin
                        stop_cnt_r <= stop_cnt_r + 16'h0001;
                    end
                    if (enc_rise) begin
                        stop_last_r <= stop_cnt_r;
                    end
                end
            endcase
        end
    end

    // Stop time, warning lamp, faults and setpoints.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stop_time_r <= 16'h0000;
            warn_lit_r <= 1'b0;
            stop_shown_r <= 1'b0;
            fault_r <= '0;
            warn_sp_r <= `BSM_WARN_RST;
            limit_sp_r <= `BSM_LIMIT_RST;
            mode_d_r <= MODE_RUN;
        end else if (clk_en_in) begin
            mode_d_r <= mode;
            if (nv_load_in) begin
                fault_r <= nv_rec_in.fault;
                stop_time_r <= nv_rec_in.stop_ms;
                warn_sp_r <= nv_rec_in.warn_sp;
                limit_sp_r <= nv_rec_in.limit_sp;
                stop_shown_r <= 1'b1;
            end else begin
                if (stop_done) begin
                    stop_time_r <= stop_last_r;
                    warn_lit_r <= over_warn;
                    stop_shown_r <= 1'b1;
                end else if (pins_s.valve_on) begin
                    stop_shown_r <= 1'b0;
                end
                // A fault arriving during reset is held for one cycle; the next cycle still in reset clears it.
                if (mode == MODE_RESET) begin
                    fault_r <= '{drive: drive_evt, brake: brake_evt};
                end else begin
                    fault_r.drive <= fault_r.drive | drive_evt;
                    fault_r.brake <= fault_r.brake | brake_evt;
                end
                if (mode == MODE_WARN_EDIT) begin
                    if (step_up && warn_sp_r != `BSM_SP_MAX) begin
                        warn_sp_r <= warn_sp_r + 10'h001;
                    end else if (step_dn && warn_sp_r != `BSM_SP_MIN) begin
                        warn_sp_r <= warn_sp_r - 10'h001;
                    end
                end
                if (mode == MODE_LIMIT_EDIT) begin
                    if (step_up && limit_sp_r != `BSM_SP_MAX) begin
                        limit_sp_r <= limit_sp_r + 10'h001;
                    end else if (step_dn && limit_sp_r != `BSM_SP_MIN) begin
                        limit_sp_r <= limit_sp_r - 10'h001;
                    end
                end
            end
        end
    end

    // Non-volatile save: on each new fault, while nv_rec_out still holds the pre-fault record, and when an edit mode is left.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            nv_save_out <= 1'b0;
            nv_rec_out <= '0;
        end else if (clk_en_in) begin
            nv_save_out <= drive_evt | brake_evt | edit_done;
            nv_rec_out <= '{fault: fault_r, stop_ms: stop_time_r,
                            warn_sp: warn_sp_r, limit_sp: limit_sp_r};
        end
    end

    // Relays, indicators and display.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            relay_on_out <= 1'b0;
            // The relays start de-energised, so not-ready must already be lit in reset.
            ind_out <= '{not_ready: 1'b1, default: 1'b0};
            display_out <= 16'h0000;
        end else if (clk_en_in) begin
            relay_on_out <= relay_nxt;
            ind_out.brake_warn <= warn_lit_r;
            ind_out.drive_fail <= fault_r.drive;
            ind_out.brake_on <= !pins_s.valve_on;
            ind_out.ready <= relay_nxt;
            ind_out.not_ready <= !relay_nxt;
            ind_out.brake_fail <= fault_r.brake;
            ind_out.warn_sp <= (mode == MODE_WARN_EDIT);
            ind_out.limit_sp <= (mode == MODE_LIMIT_EDIT);
            ind_out.speed <= !in_edit && !stop_shown_r;
            ind_out.stop_time <= !in_edit && stop_shown_r;
            if (mode == MODE_WARN_EDIT) begin
                display_out <= {6'h00, warn_sp_r};
            end else if (mode == MODE_LIMIT_EDIT) begin
                display_out <= {6'h00, limit_sp_r};
            end else if (stop_shown_r) begin
                display_out <= stop_time_r;
            end else begin
                display_out <= speed_r;
            end
        end
    end

    // Avalon-MM slave: every access waits exactly one cycle.
    wire req = avs_read_in | avs_write_in;
    wire wr_go = avs_write_in & ack_r;
    wire rd_go = avs_read_in & ~ack_r;
    wire wr_irq_stat = wr_go && avs_byteenable_in[0] && avs_address_in == `BSM_REG_IRQ_STAT;
    wire wr_irq_mask = wr_go && avs_byteenable_in[0] && avs_address_in == `BSM_REG_IRQ_MASK;
    wire wr_tmo = wr_go && avs_byteenable_in[0] && avs_address_in == `BSM_REG_DRIVE_TMO;
    wire [4:0] tmo_wd = avs_writedata_in[4:0];
    wire tmo_ok = (avs_writedata_in[7:5] == 3'h0) && (tmo_wd >= `BSM_TMO_MIN)
                  && (tmo_wd <= `BSM_TMO_MAX);
    wire [31:0] status_word = {11'h000, motion, 2'h0, fault_r, 2'h0, mode, 2'h0, ind_out};
    logic [31:0] rd_word;

    always_comb begin
        unique case (avs_address_in)
            `BSM_REG_STATUS: rd_word = status_word;
            `BSM_REG_WARN_SP: rd_word = {22'h000000, warn_sp_r};
            `BSM_REG_LIMIT_SP: rd_word = {22'h000000, limit_sp_r};
            `BSM_REG_STOP_TIME: rd_word = {16'h0000, stop_time_r};
            `BSM_REG_SPEED: rd_word = {16'h0000, speed_r};
            `BSM_REG_IRQ_STAT: rd_word = {28'h0000000, irq_stat_r};
            `BSM_REG_IRQ_MASK: rd_word = {28'h0000000, irq_mask_r};
            `BSM_REG_DRIVE_TMO: rd_word = {27'h0000000, drive_tmo_r};
            default: rd_word = 32'h00000000;
        endcase
    end

    assign avs_waitrequest_out = req & ~ack_r;
    assign irq_out = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_r <= 1'b0;
            avs_readdata_out <= 32'h00000000;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
            drive_tmo_r <= `BSM_TMO_RST;
        end else if (clk_en_in) begin
            ack_r <= req & ~ack_r;
            if (rd_go) begin
                avs_readdata_out <= rd_word;
            end
            // New events win over a write-one-to-clear in the same cycle.
            irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? avs_writedata_in[3:0] : 4'h0)) | irq_evt;
            if (wr_irq_mask) begin
                irq_mask_r <= avs_writedata_in[3:0];
            end
            if (wr_tmo && tmo_ok) begin
                drive_tmo_r <= tmo_wd;
            end
        end
    end

endmodule : bsm_monitor

// >>> bsm_monitor_chk.sv
// Port-level assertions for the brake stop time monitor.
`timescale 1ns/10ps
`include "bsm_params.svh"
module bsm_monitor_chk #(
    parameter int MS_CYCLES = 10
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire bsm_pkg::bsm_pins_t pins_in,
    input wire bsm_pkg::bsm_nv_rec_t nv_rec_out,
    input wire logic relay_on_out,
    input wire bsm_pkg::bsm_ind_t ind_out,
    input wire logic irq_out,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_waitrequest_out
);
    import bsm_pkg::*;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_req_wait;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    property p_bus_wait;
        $rose(avs_read_in) || $rose(avs_write_in) |-> s_req_wait;
    endproperty
    property p_mask_off;
        avs_write_in && !avs_waitrequest_out && avs_address_in == `BSM_REG_IRQ_MASK
            && avs_byteenable_in[0] && avs_writedata_in[3:0] == 4'h0 |=> !irq_out;
    endproperty
    property p_ready_ok;
        ind_out.ready |-> !ind_out.not_ready && !ind_out.drive_fail && !ind_out.brake_fail;
    endproperty
    property p_not_ready;
        (!relay_on_out) [*2] |-> ind_out.not_ready;
    endproperty
    // Two sync flops plus the relay register give three edges of lag, so four is safe.
    property p_key_relay;
        (pins_in.key != 2'h3) [*4] |-> !relay_on_out;
    endproperty
    property p_brake_on;
        (!pins_in.valve_on) [*5] |-> ind_out.brake_on;
    endproperty
    property p_warn_show;
        (pins_in.key == 2'h0) [*5] |-> ind_out.warn_sp && !ind_out.limit_sp;
    endproperty
    property p_limit_show;
        (pins_in.key == 2'h1) [*5] |-> ind_out.limit_sp && !ind_out.warn_sp;
    endproperty
    property p_stop_show;
        ind_out.stop_time |-> !ind_out.speed;
    endproperty
    property p_drive_relay;
        $rose(ind_out.drive_fail) |-> ##[0:2] (!relay_on_out) [*2];
    endproperty
    property p_brake_save;
        $rose(ind_out.brake_fail) |-> ##[0:3] nv_rec_out.fault.brake;
    endproperty

    a_bus_wait: assert property (p_bus_wait) else $error("bus wait cycle wrong");
    a_mask_off: assert property (p_mask_off) else $error("irq high with mask zero");
    a_ready_ok: assert property (p_ready_ok) else $error("ready lit with fault");
    a_not_ready: assert property (p_not_ready) else $error("not ready dark");
    a_key_relay: assert property (p_key_relay) else $error("relay on outside run");
    a_brake_on: assert property (p_brake_on) else $error("brake on lamp dark");
    a_warn_show: assert property (p_warn_show) else $error("warn lamp wrong");
    a_limit_show: assert property (p_limit_show) else $error("limit lamp wrong");
    a_stop_show: assert property (p_stop_show) else $error("two display lamps");
    a_drive_relay: assert property (p_drive_relay) else $error("relay kept on");
    a_brake_save: assert property (p_brake_save) else $error("fault not saved");
endmodule : bsm_monitor_chk

// >>> bsm_press_model.sv
// Crankshaft encoder and clutch/brake valve stand-in for the monitor bench.
`timescale 1ns/10ps
module bsm_press_model (
    input wire logic sys_clk_in,
    input wire logic valve_cmd_in,
    input wire logic spin_in,
    input wire logic [7:0] half_in,
    output logic valve_on_out,
    output logic enc_pulse_out
);
    logic [7:0] cnt_r = 8'h00;
    initial enc_pulse_out = 1'b0;
    initial valve_on_out = 1'b0;
    // A stopped shaft leaves the encoder at its last level, as a real one would.
    always @(posedge sys_clk_in) begin
        valve_on_out <= valve_cmd_in;
        if (!spin_in) begin
            cnt_r <= 8'h00;
        end else if (cnt_r >= half_in) begin
            cnt_r <= 8'h00;
            enc_pulse_out <= !enc_pulse_out;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule : bsm_press_model

// >>> bsm_monitor_tb.sv
// Self-checking bench for the brake stop time monitor.
`timescale 1ns/10ps
`include "bsm_params.svh"
module bsm_monitor_tb;
    import bsm_pkg::*;
    localparam int MS = 10;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [1:0] key = 2'h0;
    logic plus_btn = 1'b0;
    logic minus_btn = 1'b0;
    logic valve_cmd = 1'b0;
    logic spin = 1'b0;
    logic valve_on;
    logic enc_pulse;
    bsm_pins_t pins;
    logic nv_load = 1'b0;
    bsm_nv_rec_t nv_rec_in = '0;
    bsm_nv_rec_t nv_rec_out;
    logic nv_save;
    logic relay_on;
    logic irq;
    bsm_ind_t ind;
    logic [15:0] display;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic waitreq;
    int miscompares = 0;
    int check_count = 0;
    int saves = 0;
    int saves_at = 0;

    always #2 sys_clk_in = ~sys_clk_in;

    // Each store strobe is a one-cycle pulse, so count them on the clock.
    always @(posedge sys_clk_in) begin
        if (nv_save === 1'b1) begin
            saves++;
        end
    end
    assign pins = {key, minus_btn, plus_btn, valve_on, enc_pulse};

    bsm_press_model u_press (.sys_clk_in(sys_clk_in), .valve_cmd_in(valve_cmd),
        .spin_in(spin), .half_in(8'h03), .valve_on_out(valve_on), .enc_pulse_out(enc_pulse));
    bsm_monitor #(.MS_CYCLES(MS)) uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .clk_en_in(1'b1), .pins_in(pins), .nv_load_in(nv_load), .nv_rec_in(nv_rec_in),
        .nv_rec_out(nv_rec_out), .nv_save_out(nv_save), .relay_on_out(relay_on),
        .ind_out(ind), .display_out(display), .irq_out(irq), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic in_range(input string name, input logic [31:0] seen, input int lo,
                            input int hi);
        check(name, {31'h0, seen >= lo && seen <= hi}, 32'h1);
    endtask : in_range

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cyc

    // Request stays up until the edge that sees waitrequest low; data taken there.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge sys_clk_in);
        while (waitreq !== 1'b0) @(posedge sys_clk_in);
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic press(input logic up);
        @(posedge sys_clk_in);
        plus_btn <= up;
        minus_btn <= !up;
        cyc(10);
        plus_btn <= 1'b0;
        minus_btn <= 1'b0;
        cyc(10);
    endtask : press

    // Eight clocks per encoder pulse gives 75 pulses in the 60 ms speed window.
    task automatic stop_run(input int k);
        @(posedge sys_clk_in);
        valve_cmd <= 1'b1;
        spin <= 1'b1;
        cyc(1300);
        check("speed lamp", 32'(ind.speed), 32'h1);
        in_range("speed", 32'(display), 74, 76);
        valve_cmd <= 1'b0;
        cyc(k * MS);
        spin <= 1'b0;
        cyc(100);
        check("brake on", 32'(ind.brake_on), 32'h1);
        check("stop lamp", 32'(ind.stop_time), 32'h1);
        in_range("stop display", 32'(display), k - 2, k + 1);
        bus(1'b0, `BSM_REG_STOP_TIME, 32'h0);
        in_range("stop time", rv, k - 2, k + 1);
    endtask : stop_run

    initial begin
        cyc(16);
        reset_in <= 1'b0;
        cyc(8);
        bus(1'b0, `BSM_REG_LIMIT_SP, 32'h0);
        check("limit reset", rv, 32'hc8);
        bus(1'b0, `BSM_REG_DRIVE_TMO, 32'h0);
        check("timeout reset", rv, 32'ha);
        bus(1'b0, 6'h3c, 32'h0);
        check("unmapped", rv, 32'h0);
        check("relay edit", 32'(relay_on), 32'h0);
        check("warn display", 32'(display), 32'h64);
        press(1'b1);
        bus(1'b0, `BSM_REG_WARN_SP, 32'h0);
        check("warn plus", rv, 32'h65);
        press(1'b0);
        bus(1'b0, `BSM_REG_WARN_SP, 32'h0);
        check("warn minus", rv, 32'h64);
        key <= 2'h1;
        cyc(10);
        check("limit display", 32'(display), 32'hc8);
        press(1'b1);
        bus(1'b0, `BSM_REG_LIMIT_SP, 32'h0);
        check("limit plus", rv, 32'hc9);
        key <= 2'h2;
        press(1'b1);
        key <= 2'h0;
        spin <= 1'b1;
        cyc(20);
        press(1'b1);
        spin <= 1'b0;
        cyc(100);
        bus(1'b0, `BSM_REG_WARN_SP, 32'h0);
        check("warn locked", rv, 32'h64);
        bus(1'b1, `BSM_REG_WARN_SP, 32'h5);
        bus(1'b0, `BSM_REG_WARN_SP, 32'h0);
        check("warn read only", rv, 32'h64);
        bus(1'b1, `BSM_REG_DRIVE_TMO, 32'h1a);
        bus(1'b0, `BSM_REG_DRIVE_TMO, 32'h0);
        check("timeout range", rv, 32'ha);
        bus(1'b1, `BSM_REG_DRIVE_TMO, 32'h1);
        bus(1'b1, `BSM_REG_IRQ_MASK, 32'h1);
        key <= 2'h3;
        cyc(10);
        check("relay run", 32'(relay_on), 32'h1);
        check("ready", 32'(ind.ready), 32'h1);
        stop_run(50);
        check("no warn", 32'(ind.brake_warn), 32'h0);
        check("irq", 32'(irq), 32'h1);
        bus(1'b1, `BSM_REG_IRQ_STAT, 32'h1);
        cyc(1);
        check("irq clear", 32'(irq), 32'h0);
        stop_run(150);
        check("warn", 32'(ind.brake_warn), 32'h1);
        check("no fail", 32'(ind.brake_fail), 32'h0);
        saves_at = saves;
        stop_run(250);
        check("brake fail", 32'(ind.brake_fail), 32'h1);
        check("nv save", 32'(saves - saves_at), 32'h1);
        check("relay fault", 32'(relay_on), 32'h0);
        check("not ready", 32'(ind.not_ready), 32'h1);
        check("nv fault", 32'(nv_rec_out.fault.brake), 32'h1);
        bus(1'b0, `BSM_REG_STATUS, 32'h0);
        check("status fault", 32'(rv[17:16]), 32'h1);
        key <= 2'h2;
        cyc(10);
        check("fault cleared", 32'(ind.brake_fail), 32'h0);
        check("relay reset", 32'(relay_on), 32'h0);
        key <= 2'h3;
        valve_cmd <= 1'b1;
        cyc(1100);
        check("drive fail", 32'(ind.drive_fail), 32'h1);
        check("relay drive", 32'(relay_on), 32'h0);
        valve_cmd <= 1'b0;
        key <= 2'h2;
        cyc(10);
        key <= 2'h3;
        cyc(10);
        check("relay back", 32'(relay_on), 32'h1);
        nv_rec_in <= '{fault: 2'b10, stop_ms: 16'h0, warn_sp: 10'h05a, limit_sp: 10'h0c8};
        nv_load <= 1'b1;
        @(posedge sys_clk_in);
        nv_load <= 1'b0;
        cyc(5);
        check("restored fault", 32'(ind.drive_fail), 32'h1);
        check("restored relay", 32'(relay_on), 32'h0);
        bus(1'b0, `BSM_REG_WARN_SP, 32'h0);
        check("restored warn", rv, 32'h5a);
        bus(1'b1, `BSM_REG_IRQ_MASK, 32'h0);
        tally_and_finish();
    end

    initial begin
        cyc(60000);
        miscompares++;
        tally_and_finish();
    end
endmodule : bsm_monitor_tb

bind bsm_monitor bsm_monitor_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .pins_in(pins_in), .nv_rec_out(nv_rec_out),
    .relay_on_out(relay_on_out), .ind_out(ind_out), .irq_out(irq_out),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out));
